// [hw/smc_pkg.sv]
// Purpose: constants for the static memory controller
// Assumes: 10 MHz system clock, slower speed grade timing
// Notes: timing counts derived from nanosecond figures, except SYNC_CYCLES, set directly in cycles
package smc_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    // slower grade minimums in ns
    localparam int T_WRITE_PULSE_NS = 50;
    localparam int T_DATA_SETUP_NS = 30;
    localparam int T_ADDR_VALID_NS = 60;
    localparam int T_LANE_VALID_NS = 55;
    localparam int T_CYCLE_NS = 70;
    localparam int T_OE_ACCESS_NS = 40;
    localparam int T_TURN_OFF_NS = 25;
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    // write window must cover every minimum measured to its end
    localparam int WR_CYC_A = ns_to_cyc(T_WRITE_PULSE_NS);
    localparam int WR_CYC_B = ns_to_cyc(T_ADDR_VALID_NS);
    localparam int WR_CYC_C = ns_to_cyc(T_LANE_VALID_NS);
    localparam int WR_CYC_D = ns_to_cyc(T_DATA_SETUP_NS);
    localparam int WR_CYC = (WR_CYC_A > WR_CYC_B) ? WR_CYC_A : WR_CYC_B;
    localparam int WR_CYC2 = (WR_CYC > WR_CYC_C) ? WR_CYC : WR_CYC_C;
    localparam int WR_CYCLES = (WR_CYC2 > WR_CYC_D) ? WR_CYC2 : WR_CYC_D;
    // bus must stand through three flops and the agreement stage before sampling
    localparam int SYNC_CYCLES = 4;
    localparam int RD_CYCLES = ns_to_cyc(T_CYCLE_NS) + SYNC_CYCLES;
    localparam int OE_CYCLES = ns_to_cyc(T_OE_ACCESS_NS);
    localparam int TURN_CYCLES = ns_to_cyc(T_TURN_OFF_NS);
    localparam int REC_CYCLES = ns_to_cyc(T_CYCLE_NS);
    localparam logic [3:0] CNT_W_MAX = 4'hF;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    typedef enum logic [2:0] {
        SMC_IDLE, SMC_WRITE, SMC_READ, SMC_TURN, SMC_RETAIN, SMC_RECOVER
    } smc_state_e;
endpackage

// [hw/smc_sync.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to clk_sys
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module smc_sync
    import smc_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            out_reg <= '0;
        else
            for (int i = 0; i < W; i++)
                if (s2_reg[i] == s3_reg[i])
                    out_reg[i] <= s3_reg[i];
    end
    assign sync_out = out_reg;
endmodule
`default_nettype wire

// [hw/smc_ctrl.sv]
// Purpose: clocked controller driving an asynchronous 256K x 16 static memory
// Assumes: 10 MHz clk_sys, memory pins wired straight to the ports below
// Notes: one access at a time; the memory itself has no clock
// Function
// - one shared 16-line data bus; controller drives only when writing
// - write active at least 40 or 50 ns by grade
// - write data stable 25 or 30 ns before write end, held through
// - address valid from write start, 50 or 60 ns before end
// - lane selects asserted 50 or 55 ns before write end
// - address setup and write recovery minimums are zero
// - retention by lanes holds both lanes high, chip select low
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl
    import smc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_lanes,
    input wire logic retain_req,
    input wire logic retain_by_lanes,
    output logic retain_active,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic [ADDR_W-1:0] word_address,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic output_enable_n,
    output logic low_lane_select_n,
    output logic high_lane_select_n,
    input wire logic [DATA_W-1:0] shared_data_lines_in,
    output logic [DATA_W-1:0] shared_data_lines_out,
    output logic shared_data_lines_oe_n
);
    smc_state_e state_reg;
    logic [3:0] cnt_reg;
    logic [DATA_W-1:0] data_sync;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [1:0] lanes_reg;
    logic lanes_mode_reg;
    logic take;

    function automatic logic [3:0] cnt4(input int n);
        return n[3:0];
    endfunction

    smc_sync #(.W(DATA_W)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(shared_data_lines_in),
        .sync_out(data_sync)
    );

    // a request with no lane selected would be standby, so it is not taken
    assign req_ready = (state_reg == SMC_IDLE) && !retain_req;
    assign take = req_ready && req_valid && (req_lanes != 2'b00);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= SMC_IDLE;
            cnt_reg <= 4'h0;
        end
        else
        begin
            case (state_reg)
                SMC_IDLE:
                begin
                    if (retain_req)
                        state_reg <= SMC_RETAIN;
                    else if (take)
                    begin
                        state_reg <= req_write ? SMC_WRITE : SMC_READ;
                        // window length from rounded-up minimums
                        cnt_reg <= req_write ? cnt4(WR_CYCLES) : cnt4(RD_CYCLES);
                    end
                end
                SMC_WRITE:
                begin
                    if (cnt_reg == 4'h1)
                    begin
                        state_reg <= SMC_TURN;
                        cnt_reg <= cnt4(TURN_CYCLES);
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                end
                SMC_READ:
                begin
                    if (cnt_reg == 4'h1)
                    begin
                        state_reg <= SMC_TURN;
                        cnt_reg <= cnt4(TURN_CYCLES);
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                end
                SMC_TURN:
                begin
                    // bus released before next access can drive it
                    if (cnt_reg == 4'h1)
                        state_reg <= SMC_IDLE;
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                end
                SMC_RETAIN:
                begin
                    if (!retain_req)
                    begin
                        state_reg <= SMC_RECOVER;
                        cnt_reg <= cnt4(REC_CYCLES);
                    end
                end
                SMC_RECOVER:
                begin
                    if (cnt_reg == 4'h1)
                        state_reg <= SMC_IDLE;
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                end
                default:
                begin
                    state_reg <= SMC_IDLE;
                    cnt_reg <= 4'h0;
                end
            endcase
        end
    end

    // address, data and lanes held for the whole access
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg <= ADDR_RST;
            wdata_reg <= DATA_RST;
            lanes_reg <= 2'h0;
        end
        else if (take)
        begin
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
            lanes_reg <= req_lanes;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            lanes_mode_reg <= 1'b0;
        else if (state_reg == SMC_IDLE && retain_req)
            lanes_mode_reg <= retain_by_lanes;
    end

    // pin drive: all strobes registered, glitch free
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_address <= ADDR_RST;
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            low_lane_select_n <= 1'b1;
            high_lane_select_n <= 1'b1;
            shared_data_lines_out <= DATA_RST;
            shared_data_lines_oe_n <= 1'b1;
        end
        else
        begin
            word_address <= take ? req_addr : addr_reg;
            shared_data_lines_out <= take ? req_wdata : wdata_reg;
            if (take)
            begin
                // chip select, chosen lanes and write or output enable fall together, so start is this edge
                chip_select_n <= 1'b0;
                write_strobe_n <= !req_write;
                output_enable_n <= req_write;
                low_lane_select_n <= !req_lanes[0];
                high_lane_select_n <= !req_lanes[1];
                shared_data_lines_oe_n <= !req_write;
            end
            else if ((state_reg == SMC_WRITE || state_reg == SMC_READ)
                && cnt_reg == 4'h1)
            begin
                // all strobes rise together on this edge; bus held one more cycle
                chip_select_n <= 1'b1;
                write_strobe_n <= 1'b1;
                output_enable_n <= 1'b1;
                low_lane_select_n <= 1'b1;
                high_lane_select_n <= 1'b1;
            end
            else if (state_reg == SMC_TURN)
                shared_data_lines_oe_n <= 1'b1;
            else if (state_reg == SMC_RETAIN)
            begin
                // lane retention keeps chip select low
                chip_select_n <= !lanes_mode_reg;
                low_lane_select_n <= 1'b1;
                high_lane_select_n <= 1'b1;
                write_strobe_n <= 1'b1;
                output_enable_n <= 1'b1;
                shared_data_lines_oe_n <= 1'b1;
            end
            else if (state_reg == SMC_RECOVER)
                chip_select_n <= 1'b1;
        end
    end

    assign retain_active = (state_reg == SMC_RETAIN);

    // sample at end of read; window stretched by SYNC_CYCLES for synchroniser
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= DATA_RST;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= 1'b0;
            if (state_reg == SMC_READ && cnt_reg == 4'h1)
            begin
                rd_valid <= 1'b1;
                rd_data[7:0] <= lanes_reg[0] ? data_sync[7:0] : 8'h00;
                rd_data[15:8] <= lanes_reg[1] ? data_sync[15:8] : 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// [bench/smc_ctrl_checker.sv]
// Purpose: pin-level assertions for smc_ctrl
// Assumes: one clock domain, WR_CYCLES of 1
// Notes: bound to every smc_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl_checker
    import smc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_lanes,
    input wire logic retain_active,
    input wire logic rd_valid,
    input wire logic [ADDR_W-1:0] word_address,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic low_lane_select_n,
    input wire logic high_lane_select_n,
    input wire logic [DATA_W-1:0] shared_data_lines_out,
    input wire logic shared_data_lines_oe_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic tk;
    assign tk = req_valid && req_ready && req_lanes != 2'h0;
    wr_start_a: assert property (tk && req_write |=> !chip_select_n && !write_strobe_n
        && {high_lane_select_n, low_lane_select_n} == ~$past(req_lanes))
        else $error("write strobes wrong");
    wr_data_a: assert property (tk && req_write |=> !shared_data_lines_oe_n
        && shared_data_lines_out == $past(req_wdata) && word_address == $past(req_addr))
        else $error("write data or address wrong");
    wr_end_a: assert property (tk && req_write |=> ##1 write_strobe_n
        && !shared_data_lines_oe_n && $stable(shared_data_lines_out))
        else $error("write end wrong");
    rd_start_a: assert property (tk && !req_write |=> !chip_select_n && !output_enable_n
        && write_strobe_n && shared_data_lines_oe_n && word_address == $past(req_addr))
        else $error("read pins wrong");
    rd_done_a: assert property (tk && !req_write |-> ##6 rd_valid ##1 !rd_valid)
        else $error("read answer timing wrong");
    no_clash_a: assert property (!shared_data_lines_oe_n |-> output_enable_n)
        else $error("bus driven while memory enabled");
    no_lane_a: assert property (req_valid && req_ready && req_lanes == 2'h0
        |=> chip_select_n && shared_data_lines_oe_n)
        else $error("empty lane request acted on");
    retain_a: assert property ($past(retain_active) && retain_active |-> !req_ready
        && (chip_select_n || (low_lane_select_n && high_lane_select_n)) && write_strobe_n)
        else $error("retention pins wrong");
    cover property (tk && req_write);
    cover property (tk && !req_write);
    cover property (retain_active);
endmodule
bind smc_ctrl smc_ctrl_checker u_chk (.clk_sys, .rst_n, .req_valid, .req_ready, .req_write,
    .req_addr, .req_wdata, .req_lanes, .retain_active, .rd_valid, .word_address,
    .chip_select_n, .write_strobe_n, .output_enable_n, .low_lane_select_n,
    .high_lane_select_n, .shared_data_lines_out, .shared_data_lines_oe_n);
`default_nettype wire

// [bench/smc_mem_model.sv]
// Purpose: behavioural 256K x 16 static memory
// Assumes: zero-delay pins
// Notes: unwritten words read unknown
`timescale 1ns/1ps
`default_nettype none
module smc_mem_model
    import smc_pkg::*;
(
    input wire logic [ADDR_W-1:0] word_address,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic low_lane_select_n,
    input wire logic high_lane_select_n,
    input wire logic [DATA_W-1:0] bus,
    output logic drive_lo,
    output logic drive_hi,
    output logic [DATA_W-1:0] dout
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic wr_on;
    logic rd_on;
    logic [1:0] w_ln;
    logic [DATA_W-1:0] w_d;
    logic [ADDR_W-1:0] w_a;
    assign wr_on = !chip_select_n && !write_strobe_n
        && !(low_lane_select_n && high_lane_select_n);
    // decoded from the pins here, not from wr_on, so a stale wr_on cannot latch released lanes
    always @*
        if (!chip_select_n && !write_strobe_n && !(low_lane_select_n && high_lane_select_n))
        begin
            w_ln = {!high_lane_select_n, !low_lane_select_n};
            w_d = bus;
            w_a = word_address;
        end
    always @(negedge wr_on)
    begin
        if (w_ln[0]) mem[w_a][7:0] = w_d[7:0];
        if (w_ln[1]) mem[w_a][15:8] = w_d[15:8];
    end
    // zero delay: turn-off never trails turn-on
    assign rd_on = !chip_select_n && write_strobe_n && !output_enable_n;
    assign drive_lo = rd_on && !low_lane_select_n;
    assign drive_hi = rd_on && !high_lane_select_n;
    assign dout = mem[word_address];
endmodule
`default_nettype wire

// [bench/smc_ctrl_tb.sv]
// Purpose: self-checking bench for smc_ctrl
// Assumes: memory model answers at once
// Notes: inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl_tb;
    import smc_pkg::*;
    logic clk_sys = 0, rst_n = 0, req_valid = 0, req_write = 0;
    logic retain_req = 0, retain_by_lanes = 0;
    logic req_ready, retain_active, rd_valid, cs_n, we_n, oe_n, lb_n, hb_n, ctl_oe_n, d_lo, d_hi;
    logic [ADDR_W-1:0] req_addr = 0, wa;
    logic [DATA_W-1:0] req_wdata = 0, rd_data, ctl_out, mdo, bus, flt = 16'h5A5A;
    logic [1:0] req_lanes = 0;
    int num_errors = 0, compares = 0;
    always #50 clk_sys = ~clk_sys;
    // floating bus toggles so a stale value never passes
    always @(posedge clk_sys) flt <= ~flt;
    assign bus[7:0] = !ctl_oe_n ? ctl_out[7:0] : d_lo ? mdo[7:0] : flt[7:0];
    assign bus[15:8] = !ctl_oe_n ? ctl_out[15:8] : d_hi ? mdo[15:8] : flt[15:8];
    smc_ctrl DUT (.clk_sys, .rst_n, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
        .req_lanes, .retain_req, .retain_by_lanes, .retain_active, .rd_data, .rd_valid,
        .word_address(wa), .chip_select_n(cs_n), .write_strobe_n(we_n), .output_enable_n(oe_n),
        .low_lane_select_n(lb_n), .high_lane_select_n(hb_n), .shared_data_lines_in(bus),
        .shared_data_lines_out(ctl_out), .shared_data_lines_oe_n(ctl_oe_n));
    smc_mem_model u_mem (.word_address(wa), .chip_select_n(cs_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .low_lane_select_n(lb_n), .high_lane_select_n(hb_n),
        .bus, .drive_lo(d_lo), .drive_hi(d_hi), .dout(mdo));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic wr, input logic [17:0] a, input logic [15:0] d,
        input logic [1:0] ln);
        int n;
        @(negedge clk_sys);
        req_valid = 1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_lanes = ln;
        n = 0;
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        req_valid = 0;
        check("ready wait", 16'h0, 16'(n / 50));
        if (!wr)
        begin
            n = 0;
            while (rd_valid !== 1'b1 && n < 10)
            begin
                @(negedge clk_sys);
                n++;
            end
            check("read latency", 16'(RD_CYCLES), 16'(n));
            check("read data", d, rd_data);
        end
    endtask
    task automatic t_words;
        acc(1, 18'h3FFFF, 16'hBEEF, 2'h3);
        acc(1, 18'h00000, 16'h1234, 2'h3);
        acc(0, 18'h3FFFF, 16'hBEEF, 2'h3);
        acc(0, 18'h00000, 16'h1234, 2'h3);
    endtask
    task automatic t_bytes;
        acc(1, 18'h00000, 16'h55AB, 2'h1);
        acc(1, 18'h00000, 16'hCD66, 2'h2);
        acc(0, 18'h00000, 16'hCDAB, 2'h3);
        acc(0, 18'h00000, 16'h00AB, 2'h1);
        acc(0, 18'h00000, 16'hCD00, 2'h2);
    endtask
    task automatic t_nolane;
        @(negedge clk_sys);
        req_valid = 1;
        req_write = 1;
        req_wdata = 16'h0F0F;
        req_lanes = 0;
        repeat (4) @(negedge clk_sys);
        check("empty lanes cs_n", 16'h1, 16'(cs_n));
        req_valid = 0;
        acc(0, 18'h00000, 16'hCDAB, 2'h3);
    endtask
    task automatic t_retain(input logic by_lanes);
        @(negedge clk_sys);
        retain_req = 1;
        retain_by_lanes = by_lanes;
        repeat (4) @(negedge clk_sys);
        check("retain active", 16'h1, 16'(retain_active));
        check("retain pins", by_lanes ? 16'h3 : 16'h4,
            by_lanes ? 16'({cs_n, hb_n, lb_n}) : 16'({cs_n, 2'b00}));
        check("retain ready", 16'h0, 16'(req_ready));
        retain_req = 0;
        @(negedge clk_sys);
        check("recover wait", 16'h0, 16'(req_ready));
        acc(0, 18'h3FFFF, 16'hBEEF, 2'h3);
    endtask
    task automatic test_done;
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1;
        t_words();
        t_bytes();
        t_nolane();
        t_retain(0);
        t_retain(1);
        test_done();
    end
    initial
    begin
        #(100 * 2000);
        num_errors++;
        test_done();
    end
endmodule
`default_nettype wire
